/* File: hw/rrtx_pkg.sv */
`default_nettype none
// shared constants for the ranging response encoder on the controller side
package rrtx_pkg;

  // encoding type codes
  localparam logic [7:0] T_PWR_ADJ     = 8'h02;
  localparam logic [7:0] T_EQ_ADJ      = 8'h04;
  localparam logic [7:0] T_EQ_SET      = 8'h09;
  localparam logic [7:0] T_MAX_CODES   = 8'h0A;
  localparam logic [7:0] T_HEADROOM    = 8'h0B;
  localparam logic [7:0] T_US_ADJ      = 8'h0C;
  localparam logic [7:0] T_DRW_EDGE    = 8'h0E;
  localparam logic [7:0] T_OFDMA_ADJ   = 8'h0F;
  localparam logic [7:0] T_OFDMA_SET   = 8'h10;
  localparam logic [7:0] T_CMD_PWR     = 8'h11;
  localparam logic [7:0] T_LAST_DEF    = 8'h11;

  // length layout figures
  localparam logic [15:0] LEN1_MAX     = 16'h00FF;
  localparam logic [15:0] CP_BASE_LEN  = 16'h0005;
  localparam logic [15:0] CP_PER_CH    = 16'h0003;
  localparam logic [15:0] OF_HDR_LEN   = 16'h0003;
  localparam logic [15:0] OF_COEF_LEN  = 16'h0004;

  // reset values
  localparam logic [7:0]  TX_DATA_RST  = 8'h00;
  localparam logic [15:0] REM_RST      = 16'h0000;

  // why an item was refused
  typedef enum logic [2:0] {
    REF_NONE,
    REF_EXCL,
    REF_CONTEXT,
    REF_LENGTH,
    REF_RESERVED
  } rrtx_refuse_e;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_ITEM,
    S_TYPE,
    S_LENH,
    S_LENL,
    S_VALUE,
    S_DROP
  } rrtx_state_e;

endpackage
`default_nettype wire

/* File: hw/rrtx_policy.sv */
`timescale 1ns/10ps
`default_nettype none
// decides whether one encoding may go into the response being built
module rrtx_policy (
  // message context
  input  wire logic                  rsp_v5,
  input  wire logic                  req_v5,
  input  wire logic                  binit_v5,
  input  wire logic                  ch_ofdma,
  input  wire logic                  scdma_en,
  input  wire logic                  regmp_sent,
  input  wire logic                  cm_gen1,
  // what the message already holds
  input  wire logic                  seen_eq_adj,
  input  wire logic                  seen_eq_set,
  input  wire logic                  seen_of_adj,
  input  wire logic                  seen_of_set,
  // candidate item
  input  wire logic [7:0]            item_type,
  input  wire logic [15:0]           item_len,
  input  wire logic                  pwr_ofs,
  // verdict
  output logic                       allow,
  output rrtx_pkg::rrtx_refuse_e     code
);

  logic [15:0] cp_rest;
  logic [15:0] of_rest;

  // remainders after the fixed part of the value
  assign cp_rest = item_len - rrtx_pkg::CP_BASE_LEN;
  assign of_rest = item_len - rrtx_pkg::OF_HDR_LEN;

  // checks ordered so the most specific reason is reported
  always_comb begin
    code = rrtx_pkg::REF_NONE;
    if (item_type > rrtx_pkg::T_LAST_DEF) begin
      code = rrtx_pkg::REF_RESERVED;
    end else if (item_type == rrtx_pkg::T_OFDMA_ADJ || item_type == rrtx_pkg::T_OFDMA_SET) begin
      if (item_len < rrtx_pkg::OF_HDR_LEN || (of_rest % rrtx_pkg::OF_COEF_LEN) != 16'h0000) begin
        code = rrtx_pkg::REF_LENGTH;
      end else if (!ch_ofdma) begin
        code = rrtx_pkg::REF_CONTEXT;
      // adjust and set never mixed, repeats of one kind pass
      end else if ((item_type == rrtx_pkg::T_OFDMA_ADJ && seen_of_set)
                   || (item_type == rrtx_pkg::T_OFDMA_SET && seen_of_adj)) begin
        code = rrtx_pkg::REF_EXCL;
      end
    end else if (item_len > rrtx_pkg::LEN1_MAX) begin
      code = rrtx_pkg::REF_LENGTH;
    end else begin
      unique case (item_type)
        // no power adjust for v5 requesters
        rrtx_pkg::T_PWR_ADJ:
          if (req_v5 || binit_v5) begin
            code = rrtx_pkg::REF_CONTEXT;
          end
        rrtx_pkg::T_EQ_ADJ:
          if (seen_eq_set) begin
            code = rrtx_pkg::REF_EXCL;
          end
        rrtx_pkg::T_EQ_SET:
          if (seen_eq_adj) begin
            code = rrtx_pkg::REF_EXCL;
          end else if (cm_gen1) begin
            code = rrtx_pkg::REF_CONTEXT;
          end
        rrtx_pkg::T_MAX_CODES, rrtx_pkg::T_HEADROOM:
          if (!scdma_en) begin
            code = rrtx_pkg::REF_CONTEXT;
          end
        rrtx_pkg::T_US_ADJ:
          if (pwr_ofs && regmp_sent && req_v5) begin
            code = rrtx_pkg::REF_CONTEXT;
          end
        rrtx_pkg::T_DRW_EDGE:
          if (!regmp_sent || req_v5) begin
            code = rrtx_pkg::REF_CONTEXT;
          end
        rrtx_pkg::T_CMD_PWR:
          if (item_len < rrtx_pkg::CP_BASE_LEN || (cp_rest % rrtx_pkg::CP_PER_CH) != 16'h0000) begin
            code = rrtx_pkg::REF_LENGTH;
          end else if (!rsp_v5) begin
            code = rrtx_pkg::REF_CONTEXT;
          end
        default: code = rrtx_pkg::REF_NONE;
      endcase
    end
  end

  assign allow = (code == rrtx_pkg::REF_NONE);

endmodule
`default_nettype wire

/* File: hw/rrtx_top.sv */
// Contract
// - v5 replies to v5 or bonded requests use commanded power.
// - no power level adjust for v5 or bonded v5 requesters.
// - power level adjust allowed for v5 ofdma initial requesters; the code refuses type 2 for every v5 or bonded v5 requester.
// - never equalizer adjust (4) and set (9) in one response.
// - no equalizer set (9) to first generation modems.
// - omit types 10 and 11 while s-cdma is disabled.
// - no power offset for v5 requesters after multipart registration response.
// - omit type 14 before registration response and for v5 requesters.
// - one instance per subcarrier range, several allowed per message; the code passes repeats of 15 or 16 without comparing ranges.
// - never types 15 and 16 together in one response.
// - no types 15 or 16 for tdma or s-cdma channels.
`timescale 1ns/10ps
`default_nettype none
module rrtx_top (
  // clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  // message open, context held by caller for the handshake cycle
  input  wire logic                  MSG_VALID,
  output logic                       MSG_READY,
  input  wire logic                  MSG_RSP_V5,
  input  wire logic                  MSG_REQ_V5,
  input  wire logic                  MSG_REQ_BINIT_V5,
  input  wire logic                  MSG_CH_OFDMA,
  input  wire logic                  MSG_SCDMA_EN,
  input  wire logic                  MSG_REGMP_SENT,
  input  wire logic                  MSG_CM_GEN1,
  // item request, or end of message
  input  wire logic                  ITEM_VALID,
  output logic                       ITEM_READY,
  input  wire logic                  ITEM_END,
  input  wire logic [7:0]            ITEM_TYPE,
  input  wire logic [15:0]           ITEM_LEN,
  input  wire logic                  ITEM_PWR_OFS,
  // value bytes of the current item
  input  wire logic                  VAL_VALID,
  output logic                       VAL_READY,
  input  wire logic [7:0]            VAL_DATA,
  // encoded byte stream toward the modem
  output logic                       TX_VALID,
  input  wire logic                  TX_READY,
  output logic [7:0]                 TX_DATA,
  output logic                       TX_FIRST,
  // status
  output logic                       ITEM_ACCEPT,
  output logic                       ITEM_REFUSE,
  output rrtx_pkg::rrtx_refuse_e     REFUSE_CODE,
  output logic                       MSG_DONE,
  output logic                       MSG_ERR
);

  rrtx_pkg::rrtx_state_e  state;
  rrtx_pkg::rrtx_state_e  next_state;
  rrtx_pkg::rrtx_refuse_e pol_code;
  logic        rsp_v5, req_v5, binit_v5, ch_ofdma, scdma_en, regmp_sent, cm_gen1;
  logic        seen_eq_adj, seen_eq_set, seen_of_adj, seen_of_set, seen_cp;
  logic [7:0]  cur_type;
  logic [15:0] cur_len;
  logic [15:0] rem;
  logic        first_pend;
  logic        pol_allow;
  logic        slot_free;
  logic        msg_take;
  logic        item_take;
  logic        val_take;
  logic        need_cp;

  // two byte length only for the ofdma equalizer types
  function automatic logic long_len(input logic [7:0] t);
    long_len = (t == rrtx_pkg::T_OFDMA_ADJ) || (t == rrtx_pkg::T_OFDMA_SET);
  endfunction

  // handshakes
  assign slot_free  = !TX_VALID || TX_READY;
  assign MSG_READY  = (state == rrtx_pkg::S_IDLE);
  assign ITEM_READY = (state == rrtx_pkg::S_ITEM);
  assign VAL_READY  = (state == rrtx_pkg::S_DROP) || (state == rrtx_pkg::S_VALUE && slot_free);
  assign msg_take   = MSG_VALID && MSG_READY;
  assign item_take  = ITEM_VALID && ITEM_READY;
  assign val_take   = VAL_VALID && VAL_READY;
  // commanded power owed to v5 requesters
  assign need_cp    = rsp_v5 && (req_v5 || binit_v5);

  rrtx_policy u_policy (
    .rsp_v5      (rsp_v5),
    .req_v5      (req_v5),
    .binit_v5    (binit_v5),
    .ch_ofdma    (ch_ofdma),
    .scdma_en    (scdma_en),
    .regmp_sent  (regmp_sent),
    .cm_gen1     (cm_gen1),
    .seen_eq_adj (seen_eq_adj),
    .seen_eq_set (seen_eq_set),
    .seen_of_adj (seen_of_adj),
    .seen_of_set (seen_of_set),
    .item_type   (ITEM_TYPE),
    .item_len    (ITEM_LEN),
    .pwr_ofs     (ITEM_PWR_OFS),
    .allow       (pol_allow),
    .code        (pol_code)
  );

  // sequencer: header bytes, then value bytes or a silent drain
  always_comb begin
    next_state = state;
    unique case (state)
      rrtx_pkg::S_IDLE:
        if (msg_take) begin
          next_state = rrtx_pkg::S_ITEM;
        end
      rrtx_pkg::S_ITEM:
        if (item_take) begin
          if (ITEM_END) begin
            next_state = rrtx_pkg::S_IDLE;
          end else if (pol_allow) begin
            next_state = rrtx_pkg::S_TYPE;
          end else if (ITEM_LEN != rrtx_pkg::REM_RST) begin
            next_state = rrtx_pkg::S_DROP;
          end
        end
      // long length adds a high byte
      rrtx_pkg::S_TYPE:
        if (slot_free) begin
          next_state = long_len(cur_type) ? rrtx_pkg::S_LENH : rrtx_pkg::S_LENL;
        end
      rrtx_pkg::S_LENH:
        if (slot_free) begin
          next_state = rrtx_pkg::S_LENL;
        end
      rrtx_pkg::S_LENL:
        if (slot_free) begin
          next_state = (cur_len == rrtx_pkg::REM_RST) ? rrtx_pkg::S_ITEM : rrtx_pkg::S_VALUE;
        end
      rrtx_pkg::S_VALUE, rrtx_pkg::S_DROP:
        if (val_take && rem == 16'h0001) begin
          next_state = rrtx_pkg::S_ITEM;
        end
      default: next_state = rrtx_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= rrtx_pkg::S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // context latched once per message, stays fixed until the end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rsp_v5     <= 1'b0;
      req_v5     <= 1'b0;
      binit_v5   <= 1'b0;
      ch_ofdma   <= 1'b0;
      scdma_en   <= 1'b0;
      regmp_sent <= 1'b0;
      cm_gen1    <= 1'b0;
    end else if (msg_take) begin
      rsp_v5     <= MSG_RSP_V5;
      req_v5     <= MSG_REQ_V5;
      binit_v5   <= MSG_REQ_BINIT_V5;
      ch_ofdma   <= MSG_CH_OFDMA;
      scdma_en   <= MSG_SCDMA_EN;
      regmp_sent <= MSG_REGMP_SENT;
      cm_gen1    <= MSG_CM_GEN1;
    end
  end

  // flags record kinds, so repeats of one kind stay legal
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      seen_eq_adj <= 1'b0;
      seen_eq_set <= 1'b0;
      seen_of_adj <= 1'b0;
      seen_of_set <= 1'b0;
      seen_cp     <= 1'b0;
    end else if (msg_take) begin
      seen_eq_adj <= 1'b0;
      seen_eq_set <= 1'b0;
      seen_of_adj <= 1'b0;
      seen_of_set <= 1'b0;
      seen_cp     <= 1'b0;
    end else if (item_take && !ITEM_END && pol_allow) begin
      seen_eq_adj <= seen_eq_adj || (ITEM_TYPE == rrtx_pkg::T_EQ_ADJ);
      seen_eq_set <= seen_eq_set || (ITEM_TYPE == rrtx_pkg::T_EQ_SET);
      seen_of_adj <= seen_of_adj || (ITEM_TYPE == rrtx_pkg::T_OFDMA_ADJ);
      seen_of_set <= seen_of_set || (ITEM_TYPE == rrtx_pkg::T_OFDMA_SET);
      seen_cp     <= seen_cp || (ITEM_TYPE == rrtx_pkg::T_CMD_PWR);
    end
  end

  // current item header and byte countdown
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cur_type <= 8'h00;
      cur_len  <= rrtx_pkg::REM_RST;
      rem      <= rrtx_pkg::REM_RST;
    end else if (item_take && !ITEM_END) begin
      cur_type <= ITEM_TYPE;
      cur_len  <= ITEM_LEN;
      rem      <= ITEM_LEN;
    end else if (val_take) begin
      rem      <= rem - 16'h0001;
    end
  end

  // output byte register; a stalled modem side holds the type, length and value stages, while a drop still drains
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      TX_VALID   <= 1'b0;
      TX_DATA    <= rrtx_pkg::TX_DATA_RST;
      TX_FIRST   <= 1'b0;
      first_pend <= 1'b0;
    end else begin
      if (msg_take) begin
        first_pend <= 1'b1;
      end
      if (slot_free) begin
        TX_VALID <= 1'b0;
        TX_FIRST <= 1'b0;
        unique case (state)
          rrtx_pkg::S_TYPE: begin
            TX_VALID   <= 1'b1;
            TX_DATA    <= cur_type;
            TX_FIRST   <= first_pend;
            first_pend <= 1'b0;
          end
          rrtx_pkg::S_LENH: begin
            TX_VALID <= 1'b1;
            TX_DATA  <= cur_len[15:8];
          end
          rrtx_pkg::S_LENL: begin
            TX_VALID <= 1'b1;
            TX_DATA  <= cur_len[7:0];
          end
          rrtx_pkg::S_VALUE:
            if (VAL_VALID) begin
              TX_VALID <= 1'b1;
              TX_DATA  <= VAL_DATA;
            end
          default: TX_VALID <= 1'b0;
        endcase
      end
    end
  end

  // status pulses; the refuse code holds until the next item, the error level until the next message opens
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ITEM_ACCEPT <= 1'b0;
      ITEM_REFUSE <= 1'b0;
      REFUSE_CODE <= rrtx_pkg::REF_NONE;
      MSG_DONE    <= 1'b0;
      MSG_ERR     <= 1'b0;
    end else begin
      ITEM_ACCEPT <= item_take && !ITEM_END && pol_allow;
      ITEM_REFUSE <= item_take && !ITEM_END && !pol_allow;
      MSG_DONE    <= item_take && ITEM_END;
      if (item_take && !ITEM_END) begin
        REFUSE_CODE <= pol_code;
      end
      if (msg_take) begin
        MSG_ERR <= 1'b0;
      // missing commanded power reported at close
      end else if (item_take && ITEM_END) begin
        MSG_ERR <= need_cp && !seen_cp;
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  chk_eq_excl: assert property (!(seen_eq_adj && seen_eq_set))
    else $error("equalizer adjust and set in one message");
  chk_ofdma_excl: assert property (!(seen_of_adj && seen_of_set))
    else $error("ofdma adjust and set in one message");
  chk_gen1_set: assert property (ITEM_ACCEPT && cur_type == rrtx_pkg::T_EQ_SET |-> !cm_gen1)
    else $error("equalizer set sent to first generation modem");
  chk_scdma_omit: assert property (ITEM_ACCEPT && (cur_type == rrtx_pkg::T_MAX_CODES
                                   || cur_type == rrtx_pkg::T_HEADROOM) |-> scdma_en)
    else $error("s-cdma encoding with s-cdma disabled");
  chk_drw_omit: assert property (ITEM_ACCEPT && cur_type == rrtx_pkg::T_DRW_EDGE
                                 |-> regmp_sent && !req_v5)
    else $error("window upper edge sent too early or to v5 requester");
  chk_pwr_adj: assert property (ITEM_ACCEPT && cur_type == rrtx_pkg::T_PWR_ADJ
                                |-> !req_v5 && !binit_v5)
    else $error("power level adjust sent to v5 requester");
  chk_ofdma_chan: assert property (ITEM_ACCEPT && long_len(cur_type) |-> ch_ofdma)
    else $error("ofdma equalizer on non-ofdma channel");
  chk_cp_owed: assert property (item_take && ITEM_END && need_cp && !seen_cp |=> MSG_DONE && MSG_ERR)
    else $error("missing commanded power not reported");
  chk_long_hdr: assert property (state == rrtx_pkg::S_TYPE && slot_free && long_len(cur_type)
                                 |=> TX_VALID && TX_DATA == cur_type ##1 TX_VALID [*1])
    else $error("two byte length header not emitted");

endmodule
`default_nettype wire

/* File: verif/rrtx_modem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// modem side: takes the encoded stream and decodes it item by item
module rrtx_modem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // stream from the controller
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_first,
  input  wire logic        stall,
  output logic             tx_ready,
  // decoded results
  output logic [15:0]      items,
  output logic [7:0]       last_type,
  output logic [11:0]      last_lo,
  output logic [11:0]      last_hi,
  output logic             excl_err,
  output logic             cmd_pwr
);
  logic [1:0]  st;
  logic [15:0] len;
  logic [15:0] cnt;
  logic [23:0] hdr;
  logic [31:0] seen;
  logic        ph;

  // alternate stall cycles keep bytes waiting in the sender
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 1'h0;
      tx_ready <= 1'h0;
    end else begin
      ph <= ~ph;
      tx_ready <= ~(stall & ph);
    end
  end

  // parser: behavioural, blocking, one byte per taken beat
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st = 2'h0;
      items = 16'h0000;
      seen = 32'h0000_0000;
      excl_err = 1'h0;
      cmd_pwr = 1'h0;
      hdr = 24'h00_0000;
    end else if (tx_valid && tx_ready) begin
      if (tx_first) begin
        seen = 32'h0000_0000;
        excl_err = 1'h0;
        cmd_pwr = 1'h0;
        st = 2'h0;
      end
      case (st)
        2'h0: begin
          last_type = tx_data;
          len = 16'h0000;
          cnt = 16'h0000;
          st = (tx_data == 8'h0F || tx_data == 8'h10) ? 2'h1 : 2'h2;
        end
        2'h1: begin
          len[15:8] = tx_data;
          st = 2'h2;
        end
        2'h2: begin
          len[7:0] = tx_data;
          st = 2'h3;
        end
        default: begin
          if (cnt < 16'h0003) hdr = {hdr[15:0], tx_data};
          cnt = cnt + 16'h0001;
        end
      endcase
      // skip by length; values held raw
      if (st == 2'h3 && cnt == len) begin
        st = 2'h0;
        items = items + 16'h0001;
        // adjust or set mode, several ranges
        seen[last_type[4:0]] = 1'h1;
        // two 12-bit indices lead the value
        last_lo = hdr[23:12];
        last_hi = hdr[11:0];
        excl_err = excl_err | (seen[4] & seen[9]) | (seen[15] & seen[16]);
        cmd_pwr = cmd_pwr | seen[17];
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  // clock, reset and counters
  logic                   ref_clk;
  logic                   rst;
  int                     failures;
  int                     total_checks;
  int                     cycles;
  int                     exp_items;
  // requests: ctx is rsp_v5 req_v5 binit ofdma scdma regmp gen1
  logic                   msg_valid;
  logic [6:0]             ctx;
  logic                   item_valid;
  logic                   item_end;
  logic [7:0]             item_type;
  logic [15:0]            item_len;
  logic                   item_pwr_ofs;
  logic                   val_valid;
  logic [7:0]             val_data;
  logic                   stall;
  // observed
  logic                   msg_ready, item_ready, val_ready, tx_valid, tx_ready, tx_first;
  logic                   item_accept, item_refuse, msg_done, msg_err, excl_err, cmd_pwr;
  logic [7:0]             tx_data, last_type;
  logic [11:0]            last_lo, last_hi;
  logic [15:0]            items;
  rrtx_pkg::rrtx_refuse_e refuse_code;

  rrtx_top dut (
    .REF_CLK(ref_clk), .RST(rst), .MSG_VALID(msg_valid), .MSG_READY(msg_ready),
    .MSG_RSP_V5(ctx[6]), .MSG_REQ_V5(ctx[5]), .MSG_REQ_BINIT_V5(ctx[4]),
    .MSG_CH_OFDMA(ctx[3]), .MSG_SCDMA_EN(ctx[2]), .MSG_REGMP_SENT(ctx[1]),
    .MSG_CM_GEN1(ctx[0]), .ITEM_VALID(item_valid), .ITEM_READY(item_ready),
    .ITEM_END(item_end), .ITEM_TYPE(item_type), .ITEM_LEN(item_len),
    .ITEM_PWR_OFS(item_pwr_ofs), .VAL_VALID(val_valid), .VAL_READY(val_ready),
    .VAL_DATA(val_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .TX_FIRST(tx_first), .ITEM_ACCEPT(item_accept), .ITEM_REFUSE(item_refuse),
    .REFUSE_CODE(refuse_code), .MSG_DONE(msg_done), .MSG_ERR(msg_err));

  rrtx_modem_model modem (
    .clk(ref_clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_first(tx_first), .stall(stall), .tx_ready(tx_ready), .items(items),
    .last_type(last_type), .last_lo(last_lo), .last_hi(last_hi),
    .excl_err(excl_err), .cmd_pwr(cmd_pwr));

  // free-running clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // hang guard, well above the several hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0b seen %0b", nm, e, g);
    end
  endtask

  task automatic cmp_code(input string nm, input rrtx_pkg::rrtx_refuse_e e,
                          input rrtx_pkg::rrtx_refuse_e g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic cmp_num(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // bounded wait for a handshake or answer, sampled as the edge saw it
  task automatic wait_for(input int k, input string nm);
    int   n;
    logic hit;
    n = 0;
    hit = 1'h0;
    while (hit !== 1'h1 && n < 600) begin
      @(posedge ref_clk);
      n++;
      hit = (k == 0) ? msg_ready : (k == 1) ? item_ready :
            (k == 2) ? (item_accept | item_refuse) : msg_done;
    end
    cmp_bit(nm, 1'h1, hit);
  endtask

  task automatic open_msg(input logic [6:0] c);
    @(posedge ref_clk);
    ctx <= c;
    msg_valid <= 1'h1;
    wait_for(0, "msg_ready");
    msg_valid <= 1'h0;
  endtask

  // value bytes run 01, 02, 03 ... so index fields are known
  task automatic send_item(input logic [7:0] t, input logic [15:0] len, input logic ofs,
                           input logic acc, input rrtx_pkg::rrtx_refuse_e code);
    int i;
    int n;
    @(posedge ref_clk);
    item_type <= t;
    item_len <= len;
    item_pwr_ofs <= ofs;
    item_valid <= 1'h1;
    wait_for(1, "item_ready");
    item_valid <= 1'h0;
    wait_for(2, "item_answer");
    cmp_bit("item_accept", acc, item_accept);
    cmp_bit("item_refuse", !acc, item_refuse);
    cmp_code("refuse_code", code, refuse_code);
    i = 0;
    n = 0;
    val_valid <= (len != 16'h0000);
    val_data <= 8'h01;
    while (i < len && n < 2000) begin
      @(posedge ref_clk);
      n++;
      if (val_ready === 1'h1) begin
        i++;
        val_data <= 8'(i + 1);
      end
    end
    val_valid <= 1'h0;
    if (acc === 1'h1) exp_items++;
  endtask

  task automatic close_msg(input logic err);
    @(posedge ref_clk);
    item_end <= 1'h1;
    item_valid <= 1'h1;
    wait_for(1, "item_ready");
    item_valid <= 1'h0;
    item_end <= 1'h0;
    wait_for(3, "msg_done");
    cmp_bit("msg_err", err, msg_err);
  endtask

  // let the modem finish decoding what was accepted
  task automatic drain();
    int n;
    n = 0;
    while (items !== 16'(exp_items) && n < 600) begin
      @(posedge ref_clk);
      n++;
    end
    cmp_num("items", 16'(exp_items), items);
  endtask

  task automatic chk_refuse(input logic [6:0] c, input logic [7:0] t, input logic [15:0] len,
                            input logic ofs, input rrtx_pkg::rrtx_refuse_e code);
    open_msg(c);
    send_item(t, len, ofs, 1'h0, code);
    close_msg(1'h0);
  endtask

  task automatic s_reset();
    @(posedge ref_clk);
    cmp_bit("msg_ready", 1'h1, msg_ready);
    cmp_bit("item_ready", 1'h0, item_ready);
    cmp_bit("tx_valid", 1'h0, tx_valid);
  endtask

  task automatic s_ofdma();
    open_msg(7'h08);
    send_item(8'h10, 16'h0007, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h10, 16'h0003, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h0F, 16'h0007, 1'h0, 1'h0, rrtx_pkg::REF_EXCL);
    close_msg(1'h0);
    drain();
    cmp_num("last_type", 16'h0010, {8'h00, last_type});
    cmp_num("low_index", 16'h0010, {4'h0, last_lo});
    cmp_num("high_index", 16'h0203, {4'h0, last_hi});
    cmp_bit("excl_err", 1'h0, excl_err);
    open_msg(7'h08);
    send_item(8'h0F, 16'h0003, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h10, 16'h0003, 1'h0, 1'h0, rrtx_pkg::REF_EXCL);
    close_msg(1'h0);
    drain();
  endtask

  task automatic s_refusals();
    chk_refuse(7'h20, 8'h02, 16'h0001, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h10, 8'h02, 16'h0001, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h01, 8'h09, 16'h0004, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h00, 8'h0A, 16'h0001, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h00, 8'h0B, 16'h0001, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h00, 8'h0E, 16'h0001, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h22, 8'h0E, 16'h0001, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h22, 8'h0C, 16'h0003, 1'h1, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h00, 8'h0F, 16'h0003, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h00, 8'h10, 16'h0003, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h00, 8'h11, 16'h0005, 1'h0, rrtx_pkg::REF_CONTEXT);
    chk_refuse(7'h00, 8'h12, 16'h0001, 1'h0, rrtx_pkg::REF_RESERVED);
    chk_refuse(7'h40, 8'h11, 16'h0006, 1'h0, rrtx_pkg::REF_LENGTH);
    chk_refuse(7'h08, 8'h10, 16'h0006, 1'h0, rrtx_pkg::REF_LENGTH);
    chk_refuse(7'h00, 8'h01, 16'h0100, 1'h0, rrtx_pkg::REF_LENGTH);
    drain();
  endtask

  // modem stalls every other cycle here
  task automatic s_accepts();
    stall <= 1'h1;
    open_msg(7'h06);
    send_item(8'h02, 16'h0001, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h0A, 16'h0001, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h0B, 16'h0001, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h0E, 16'h0001, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h0C, 16'h0003, 1'h1, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h09, 16'h0004, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h04, 16'h0004, 1'h0, 1'h0, rrtx_pkg::REF_EXCL);
    close_msg(1'h0);
    drain();
    stall <= 1'h0;
  endtask

  task automatic s_cmd_pwr();
    open_msg(7'h50);
    send_item(8'h01, 16'h0004, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    close_msg(1'h1);
    open_msg(7'h62);
    send_item(8'h11, 16'h0008, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h0C, 16'h0003, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h04, 16'h0002, 1'h0, 1'h1, rrtx_pkg::REF_NONE);
    send_item(8'h09, 16'h0002, 1'h0, 1'h0, rrtx_pkg::REF_EXCL);
    close_msg(1'h0);
    drain();
    cmp_bit("cmd_pwr", 1'h1, cmd_pwr);
  endtask

  // main sequence
  initial begin
    rst = 1'h1;
    msg_valid = 1'h0;
    ctx = 7'h00;
    item_valid = 1'h0;
    item_end = 1'h0;
    item_type = 8'h00;
    item_len = 16'h0000;
    item_pwr_ofs = 1'h0;
    val_valid = 1'h0;
    val_data = 8'h00;
    stall = 1'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    s_reset();
    s_ofdma();
    s_refusals();
    s_accepts();
    s_cmd_pwr();
    print_verdict();
  end
endmodule
`default_nettype wire
